/* rtl/uart_pkg.sv */
package uart_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int DATA_W = 9;
  localparam int PRESCALE_W = 8;
  localparam int RX_DEPTH = 2;

  // ------------------------------------------------------------
  // Bit timing, sixteen ticks per bit
  // ------------------------------------------------------------
  localparam logic [3:0] PHASE_LAST = 4'hf;
  localparam logic [3:0] VOTE_A = 4'h7;
  localparam logic [3:0] VOTE_B = 4'h8;
  localparam logic [3:0] DECIDE = 4'h9;
  localparam logic [3:0] STOP_DONE = 4'ha;

  // ------------------------------------------------------------
  // Field positions and masks
  // ------------------------------------------------------------
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  localparam logic [8:0] MASK_8 = 9'h0ff;
  localparam logic [8:0] MASK_9 = 9'h1ff;

  // ------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------
  localparam logic TRANSMIT_EMPTY_FLAG_RESET = 1'b1;
  localparam logic TRANSMITTER_IDLE_FLAG_RESET = 1'b1;
  localparam logic RIDLE_RESET = 1'b1;
  localparam logic LINE_IDLE = 1'b1;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_START = 3'h1,
    TX_DATA = 3'h2,
    TX_PARITY = 3'h3,
    TX_STOP1 = 3'h4,
    TX_STOP2 = 3'h5
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h2,
    RX_PARITY = 3'h3,
    RX_STOP = 3'h4
  } rx_state_t;

endpackage

/* rtl/two_entry_buffer.sv */
`timescale 1ns/100ps
module two_entry_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Word in
  output logic out_valid, // Head holds a word
  input wire logic out_ready, // Head taken
  output logic [WIDTH-1:0] out_data, // Head word
  output logic full // No room left
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [CW-1:0] count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = count != CW'(DEPTH);
  assign full = !in_ready;
  assign out_valid = count != '0;
  assign out_data = mem[0];

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Entries, head at index zero
  // ------------------------------------------------------------
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      logic [WIDTH-1:0] upper;
      if (i == DEPTH - 1) begin : g_top
        assign upper = in_data;
      end else begin : g_mid
        assign upper = (push && count == CW'(i + 1)) ? in_data : mem[i + 1];
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          mem[i] <= '0;
        end else if (pop) begin
          mem[i] <= upper;
        end else if (push && count == CW'(i)) begin
          mem[i] <= in_data;
        end
      end
    end
  endgenerate

  full_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    full && !out_ready |=> full && out_valid)
    else $error("buffer lost a word while stalled");

endmodule

/* rtl/async_serial_transceiver.sv */
`timescale 1ns/100ps
module async_serial_transceiver (
  input wire logic clk, // System clock, 50 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic serial_global_enable, // Whole block on
  input wire logic transmit_enable_bit, // Transmitter on
  input wire logic receive_enable_bit, // Receiver on
  input wire logic nine_bit_mode, // Nine data bits
  input wire logic parity_enable, // Parity bit present
  input wire logic parity_odd, // Odd parity when set
  input wire logic two_stop_bits, // Second stop bit sent
  input wire logic address_mode, // Address detection on
  input wire logic [uart_pkg::PRESCALE_W-1:0] prescaler, // Tick divisor
  input wire logic status_read, // Status read strobe
  input wire logic data_write, // Data write strobe
  input wire logic [uart_pkg::DATA_W-1:0] data_in, // Word to send
  input wire logic data_read, // Data read strobe
  input wire logic rx_in, // Receive pin level
  output logic tx_out, // Transmit pin level
  output logic tx_oe, // Transmit pin driven
  output logic rx_claim, // Receive pin owned
  output logic [uart_pkg::DATA_W-1:0] data_out, // Received word
  output logic transmit_empty_flag, // Holding register empty
  output logic transmitter_idle_flag, // Nothing being sent
  output logic receive_available_flag, // Received word waiting
  output logic receiver_idle_flag, // No frame arriving
  output logic overrun_flag, // Word lost, buffer full
  output logic framing_error_flag, // Stop bit read low
  output logic parity_error_flag, // Parity mismatch
  output logic noise_flag, // Samples disagreed
  output logic address_detect_flag, // Address word seen
  output logic rx_edge_flag // Falling edge pulse
);
  import uart_pkg::*;

  tx_state_t tx_state;
  rx_state_t rx_state;
  logic tx_on;
  logic rx_on;
  logic [PRESCALE_W-1:0] baud_cnt;
  logic tick;
  logic [3:0] last_bit;
  logic [DATA_W-1:0] data_mask;
  logic [DATA_W-1:0] hold_data;
  logic [DATA_W-1:0] tx_shift;
  logic hold_full;
  logic tx_par;
  logic tx_seen;
  logic [3:0] tx_phase;
  logic [3:0] tx_bit;
  logic tx_load;
  logic tx_end;
  logic rx_meta;
  logic rx_sync;
  logic rx_prev;
  logic rx_fall;
  logic [3:0] rx_phase;
  logic [3:0] rx_bit;
  logic [DATA_W-1:0] rx_shift;
  logic [DATA_W-1:0] rx_word;
  logic vote_a;
  logic vote_b;
  logic samp_bit;
  logic samp_noisy;
  logic rx_noisy;
  logic rx_par;
  logic rx_parity_error_flag;
  logic rx_end;
  logic rx_done;
  logic rx_accept;
  logic buf_in_ready;
  logic buf_full;
  logic rx_seen;
  logic err_clear;

  assign tx_on = serial_global_enable && transmit_enable_bit;
  assign rx_on = serial_global_enable && receive_enable_bit;
  assign last_bit = nine_bit_mode ? LAST_BIT_9 : LAST_BIT_8;
  assign data_mask = nine_bit_mode ? MASK_9 : MASK_8;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // Baud tick, sixteen per bit
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || !serial_global_enable) begin
      baud_cnt <= '0;
      tick <= 1'b0;
    end else if (baud_cnt == prescaler) begin
      baud_cnt <= '0;
      tick <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  baud_tick_a: assert property (
    tick && prescaler != '0 && $stable(prescaler) |=> !tick)
    else $error("baud tick too close");

  // ------------------------------------------------------------
  // Pin ownership
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_oe <= 1'b0;
      rx_claim <= 1'b0;
    end else begin
      tx_oe <= tx_on;
      rx_claim <= rx_on;
    end
  end

  tx_pin_a: assert property (!tx_on |=> !tx_oe)
    else $error("transmit pin driven while off");
  rx_pin_a: assert property (!rx_on |=> !rx_claim)
    else $error("receive pin claimed while off");
  pin_take_a: assert property (
    tx_on && rx_on ##1 tx_on && rx_on |-> tx_oe && rx_claim)
    else $error("pins not taken over");

  // ------------------------------------------------------------
  // Transmit holding register
  // ------------------------------------------------------------
  assign tx_load = tx_on && tx_state == TX_IDLE && hold_full;
  assign tx_end = tick && tx_phase == PHASE_LAST;

  always_ff @(posedge clk) begin
    if (rst) begin
      hold_data <= '0;
    end else if (data_write) begin
      hold_data <= data_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !tx_on) begin
      hold_full <= 1'b0;
    end else if (data_write) begin
      hold_full <= 1'b1;
    end else if (tx_load) begin
      hold_full <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_seen <= 1'b0;
    end else if (status_read) begin
      tx_seen <= 1'b1;
    end else if (data_write) begin
      tx_seen <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !tx_on) begin
      transmit_empty_flag <= TRANSMIT_EMPTY_FLAG_RESET;
    end else if (tx_load) begin
      transmit_empty_flag <= 1'b1;
    end else if (data_write && tx_seen) begin
      transmit_empty_flag <= 1'b0;
    end
  end

  transmit_empty_flag_clear_a: assert property (
    $fell(transmit_empty_flag) && tx_oe |-> $past(data_write) && $past(tx_seen))
    else $error("empty flag cleared without sequence");

  always_ff @(posedge clk) begin
    if (rst || !tx_on) begin
      transmitter_idle_flag <= TRANSMITTER_IDLE_FLAG_RESET;
    end else if (tx_state == TX_IDLE && !hold_full && !data_write &&
                 transmit_empty_flag) begin
      transmitter_idle_flag <= 1'b1;
    end else if (tx_load || (data_write && tx_seen)) begin
      transmitter_idle_flag <= 1'b0;
    end
  end

  transmitter_idle_flag_line_a: assert property (
    transmitter_idle_flag && tx_oe |-> tx_out && tx_state == TX_IDLE)
    else $error("idle flag with line not idle");

  // ------------------------------------------------------------
  // Transmit shifter
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || !tx_on) begin
      tx_state <= TX_IDLE;
      tx_phase <= '0;
      tx_bit <= '0;
      tx_shift <= '0;
      tx_par <= 1'b0;
    end else begin
      tx_phase <= (tx_state == TX_IDLE) ? 4'h0 :
                  (tick ? tx_phase + 4'h1 : tx_phase);
      unique case (tx_state)
        TX_IDLE: if (hold_full) begin
          tx_state <= TX_START;
          tx_shift <= hold_data;
          tx_par <= ^(hold_data & data_mask) ^ parity_odd;
        end
        TX_START: if (tx_end) begin
          tx_state <= TX_DATA;
          tx_bit <= '0;
        end
        TX_DATA: if (tx_end) begin
          tx_shift <= tx_shift >> 1;
          tx_bit <= tx_bit + 4'h1;
          if (tx_bit == last_bit) begin
            tx_state <= parity_enable ? TX_PARITY : TX_STOP1;
          end
        end
        TX_PARITY: if (tx_end) begin
          tx_state <= TX_STOP1;
        end
        TX_STOP1: if (tx_end) begin
          tx_state <= two_stop_bits ? TX_STOP2 : TX_IDLE;
        end
        TX_STOP2: if (tx_end) begin
          tx_state <= TX_IDLE;
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !tx_on) begin
      tx_out <= LINE_IDLE;
    end else begin
      unique case (tx_state)
        TX_START: tx_out <= 1'b0;
        TX_DATA: tx_out <= tx_shift[0];
        TX_PARITY: tx_out <= tx_par;
        default: tx_out <= LINE_IDLE;
      endcase
    end
  end

  sequence tx_launch_s;
    tx_load ##1 tx_on [*8];
  endsequence

  tx_start_a: assert property (tx_launch_s |=> !tx_out)
    else $error("start bit not low");
  tx_load_a: assert property (
    tx_load |=> tx_state == TX_START && tx_shift == $past(hold_data))
    else $error("held word not moved to shifter");

  // ------------------------------------------------------------
  // Receive input synchroniser and edge
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_meta <= LINE_IDLE;
      rx_sync <= LINE_IDLE;
      rx_prev <= LINE_IDLE;
    end else begin
      rx_meta <= rx_in;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  assign rx_fall = rx_prev && !rx_sync;

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_edge_flag <= 1'b0;
    end else begin
      rx_edge_flag <= rx_on && rx_fall;
    end
  end

  // ------------------------------------------------------------
  // Three-sample vote near bit centre
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      vote_a <= LINE_IDLE;
      vote_b <= LINE_IDLE;
      samp_bit <= LINE_IDLE;
      samp_noisy <= 1'b0;
    end else if (tick) begin
      if (rx_phase == VOTE_A) begin
        vote_a <= rx_sync;
      end
      if (rx_phase == VOTE_B) begin
        vote_b <= rx_sync;
      end
      if (rx_phase == DECIDE) begin
        samp_bit <= (vote_a && vote_b) || (vote_a && rx_sync) ||
                    (vote_b && rx_sync);
        samp_noisy <= !(vote_a == vote_b && vote_b == rx_sync);
      end
    end
  end

  // ------------------------------------------------------------
  // Receive shifter
  // ------------------------------------------------------------
  assign rx_end = tick && rx_phase == PHASE_LAST;
  assign rx_done = rx_on && rx_state == RX_STOP && tick &&
                   rx_phase == STOP_DONE;
  assign rx_word = nine_bit_mode ? rx_shift : {1'b0, rx_shift[8:1]};

  always_ff @(posedge clk) begin
    if (rst || !rx_on) begin
      rx_state <= RX_IDLE;
      rx_phase <= '0;
      rx_bit <= '0;
      rx_shift <= '0;
      rx_noisy <= 1'b0;
      rx_par <= 1'b0;
      rx_parity_error_flag <= 1'b0;
    end else begin
      rx_phase <= (rx_state == RX_IDLE) ? 4'h0 :
                  (tick ? rx_phase + 4'h1 : rx_phase);
      unique case (rx_state)
        RX_IDLE: if (rx_fall) begin
          rx_state <= RX_START;
          rx_noisy <= 1'b0;
          rx_par <= 1'b0;
          rx_parity_error_flag <= 1'b0;
          rx_shift <= '0;
        end
        RX_START: if (rx_end) begin
          rx_noisy <= samp_noisy;
          rx_bit <= '0;
          rx_state <= samp_bit ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_end) begin
          rx_shift <= {samp_bit, rx_shift[8:1]};
          rx_par <= rx_par ^ samp_bit;
          rx_noisy <= rx_noisy || samp_noisy;
          rx_bit <= rx_bit + 4'h1;
          if (rx_bit == last_bit) begin
            rx_state <= parity_enable ? RX_PARITY : RX_STOP;
          end
        end
        RX_PARITY: if (rx_end) begin
          rx_parity_error_flag <= samp_bit != (rx_par ^ parity_odd);
          rx_noisy <= rx_noisy || samp_noisy;
          rx_state <= RX_STOP;
        end
        RX_STOP: if (rx_done) begin
          rx_state <= RX_IDLE;
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  sequence rx_fall_s;
    rx_on && rx_state == RX_IDLE && rx_fall;
  endsequence

  rx_start_a: assert property (
    rx_fall_s |=> rx_state == RX_START && rx_phase == 4'h0)
    else $error("falling edge did not start a frame");

  always_ff @(posedge clk) begin
    if (rst) begin
      receiver_idle_flag <= RIDLE_RESET;
    end else begin
      receiver_idle_flag <= rx_state == RX_IDLE;
    end
  end

  // ------------------------------------------------------------
  // Receive buffer and its flags
  // ------------------------------------------------------------
  two_entry_buffer #(
    .WIDTH(DATA_W),
    .DEPTH(RX_DEPTH)
  ) rx_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(rx_done && !overrun_flag),
    .in_ready(buf_in_ready),
    .in_data(rx_word),
    .out_valid(),
    .out_ready(data_read),
    .out_data(data_out),
    .full(buf_full)
  );

  assign rx_accept = rx_done && !overrun_flag && buf_in_ready;
  assign err_clear = rx_seen && data_read;

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_seen <= 1'b0;
    end else if (status_read) begin
      rx_seen <= 1'b1;
    end else if (data_read) begin
      rx_seen <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      receive_available_flag <= 1'b0;
    end else if (rx_accept) begin
      receive_available_flag <= 1'b1;
    end else if (err_clear && !buf_full) begin
      receive_available_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      overrun_flag <= 1'b0;
    end else if (rx_done && !buf_in_ready) begin
      overrun_flag <= 1'b1;
    end else if (err_clear) begin
      overrun_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      noise_flag <= 1'b0;
    end else if (rx_accept && (rx_noisy || samp_noisy)) begin
      noise_flag <= 1'b1;
    end else if (err_clear) begin
      noise_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      framing_error_flag <= 1'b0;
    end else if (rx_accept && !samp_bit) begin
      framing_error_flag <= 1'b1;
    end else if (err_clear) begin
      framing_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      parity_error_flag <= 1'b0;
    end else if (rx_accept && parity_enable && rx_parity_error_flag) begin
      parity_error_flag <= 1'b1;
    end else if (err_clear) begin
      parity_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      address_detect_flag <= 1'b0;
    end else if (rx_accept && address_mode && rx_shift[8]) begin
      address_detect_flag <= 1'b1;
    end else if (err_clear) begin
      address_detect_flag <= 1'b0;
    end
  end

  err_align_a: assert property (
    $rose(framing_error_flag) || $rose(noise_flag) |->
      receive_available_flag && $past(rx_accept))
    else $error("error flag not aligned with word");
  ovr_block_a: assert property (
    overrun_flag && !data_read |=> $stable(data_out))
    else $error("word accepted during overrun");
  noise_ovr_a: assert property (
    $rose(overrun_flag) |-> !$rose(noise_flag))
    else $error("noise set on an overrun");
  addr_a: assert property (
    rx_accept && address_mode && rx_shift[8] |=> address_detect_flag)
    else $error("address word not flagged");

endmodule

/* test/serial_peer.sv */
`timescale 1ns/100ps
module serial_peer (
  input wire logic clk, // System clock
  input wire logic tx_line, // Line from the block
  input wire logic nine, // Nine data bits
  input wire logic par_en, // Parity present
  input wire logic par_odd, // Odd parity
  input wire logic [7:0] scale, // Tick divisor of the block
  output logic rx_line, // Line to the block, idles high
  output logic got, // Word captured
  output logic [9:0] got_word // Frame good and word
);
  logic [8:0] w;
  logic ok;
  int i;
  initial begin
    rx_line = 1'b1;
    got = 1'b0;
    got_word = 10'h000;
  end
  task automatic put(input logic b);
    rx_line = b;
    repeat (16 * (scale + 1)) @(negedge clk);
  endtask
  // bad[0] flips parity, bad[1] sends a low stop bit
  task automatic send(input logic [8:0] d, input logic [1:0] bad);
    logic [8:0] v;
    v = nine ? d : {1'b0, d[7:0]};
    put(1'b0);
    for (int k = 0; k < (nine ? 9 : 8); k++) begin
      put(v[k]);
    end
    if (par_en) begin
      put(^v ^ par_odd ^ bad[0]);
    end
    put(~bad[1]);
    rx_line = 1'b1;
  endtask
  always begin
    @(negedge tx_line);
    repeat (8 * (scale + 1)) @(posedge clk);
    ok = (tx_line == 1'b0);
    w = 9'h000;
    for (i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (16 * (scale + 1)) @(posedge clk);
      w[i] = tx_line;
    end
    if (par_en) begin
      repeat (16 * (scale + 1)) @(posedge clk);
      ok = ok & (tx_line == (^w ^ par_odd));
    end
    repeat (16 * (scale + 1)) @(posedge clk);
    got_word <= {ok & tx_line, w};
    got <= 1'b1;
    @(posedge clk);
    got <= 1'b0;
  end
endmodule

/* test/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import uart_pkg::*;
  logic clk, rst, gen, ten, ren, nine_bit_mode, parity_enable, parity_odd;
  logic two_stop_bits, address_mode, status_read, data_write, data_read;
  logic [8:0] data_in, data_out, a, b, rq;
  logic [8:0] ov [3];
  logic rx_in, tx_out, tx_oe, rx_claim, got;
  logic transmit_empty_flag, transmitter_idle_flag, receive_available_flag;
  logic overrun_flag, framing_error_flag, parity_error_flag;
  logic address_detect_flag, noise_flag, receiver_idle_flag, rx_edge_flag;
  logic [7:0] prescaler;
  logic [9:0] got_word, tq;
  logic [31:0] seed;
  logic [9:0] txq [$];
  logic [8:0] rxq [$];
  int n_fail, samples_checked, cycles, m, k;
`define CHK(x, y) begin samples_checked++; if ((x) !== (y)) begin n_fail++; \
  $display("wrong value at %0t: %h, expected %h", $time, x, y); end end
  async_serial_transceiver i_async_serial_transceiver (.clk(clk),
    .rst(rst), .serial_global_enable(gen), .transmit_enable_bit(ten),
    .receive_enable_bit(ren), .nine_bit_mode(nine_bit_mode),
    .parity_enable(parity_enable), .parity_odd(parity_odd),
    .two_stop_bits(two_stop_bits), .address_mode(address_mode),
    .prescaler(prescaler), .status_read(status_read),
    .data_write(data_write),
    .data_in(data_in), .data_read(data_read), .rx_in(rx_in),
    .tx_out(tx_out), .tx_oe(tx_oe), .rx_claim(rx_claim),
    .data_out(data_out), .transmit_empty_flag(transmit_empty_flag),
    .transmitter_idle_flag(transmitter_idle_flag),
    .receive_available_flag(receive_available_flag),
    .receiver_idle_flag(receiver_idle_flag), .overrun_flag(overrun_flag),
    .framing_error_flag(framing_error_flag),
    .parity_error_flag(parity_error_flag), .noise_flag(noise_flag),
    .address_detect_flag(address_detect_flag),
    .rx_edge_flag(rx_edge_flag));
  serial_peer i_serial_peer (.clk(clk), .tx_line(tx_out),
    .nine(nine_bit_mode), .par_en(parity_enable), .par_odd(parity_odd),
    .scale(prescaler), .rx_line(rx_in), .got(got), .got_word(got_word));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [8:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[8:0];
  endfunction
  task close_out;
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Watchers
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      close_out();
    end
    if (got) begin
      tq = txq.pop_front();
      `CHK(got_word, tq)
    end
    if (data_read && receive_available_flag) begin
      rq = rxq.pop_front();
      `CHK(data_out, rq)
    end
  end
  // ------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------
  task automatic send_tx(input logic [8:0] d);
    int k;
    k = 0;
    txq.push_back({1'b1, nine_bit_mode ? d : {1'b0, d[7:0]}});
    status_read = 1'b1;
    @(negedge clk);
    status_read = 1'b0;
    data_in = d;
    data_write = 1'b1;
    @(negedge clk);
    `CHK({transmit_empty_flag, transmitter_idle_flag}, 2'h0)
    data_write = 1'b0;
    @(negedge clk);
    `CHK(transmit_empty_flag, 1'b1)
    repeat (4) @(negedge clk);
    while (!transmitter_idle_flag && k < 3000) begin
      @(negedge clk);
      k++;
    end
    `CHK({transmitter_idle_flag, tx_out}, 2'h3)
  endtask
  task automatic rd(input logic [8:0] e, input logic [2:0] f);
    int k;
    k = 0;
    while (receive_available_flag !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    `CHK({address_detect_flag, parity_error_flag}, f[2:1])
    `CHK({framing_error_flag, noise_flag}, {f[0], 1'b0})
    rxq.push_back(e);
    status_read = 1'b1;
    @(negedge clk);
    status_read = 1'b0;
    data_read = 1'b1;
    @(negedge clk);
    data_read = 1'b0;
  endtask
  initial begin
    {gen, ten, ren, nine_bit_mode, parity_enable, parity_odd} = 6'h00;
    {two_stop_bits, address_mode, status_read, data_write} = 4'h0;
    data_read = 1'b0;
    data_in = 9'h000;
    prescaler = 8'h00;
    seed = 32'habee9dfc;
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    `CHK({transmit_empty_flag, transmitter_idle_flag}, 2'h3)
    `CHK({tx_oe, rx_claim, tx_out, receiver_idle_flag}, 4'h3)
    `CHK(tx_oe, 1'b0)
    {gen, ten, ren, address_mode} = 4'hf;
    repeat (2) @(negedge clk);
    `CHK({tx_oe, rx_claim}, 2'h3)
    for (m = 0; m < 6; m++) begin
      nine_bit_mode = m[0];
      two_stop_bits = m[1];
      parity_enable = (m > 1);
      parity_odd = (m > 3);
      prescaler = {7'h00, m[2]};
      a = rnd();
      b = rnd();
      fork
        send_tx(a);
        i_serial_peer.send(b, 2'h0);
        begin
          k = 0;
          while (!rx_edge_flag && k < 8) begin
            @(negedge clk);
            k++;
          end
          `CHK(rx_edge_flag, 1'b1)
          repeat (40) @(negedge clk);
          `CHK(receiver_idle_flag, 1'b0)
        end
      join
      rd(m[0] ? b : {1'b0, b[7:0]}, {m[0] ? b[8] : b[7], 2'h0});
    end
    nine_bit_mode = 1'b0;
    for (m = 0; m < 3; m++) begin
      ov[m] = rnd() & 9'h07f;
      i_serial_peer.send(ov[m], 2'h0);
    end
    `CHK(overrun_flag, 1'b1)
    rd(ov[0], 3'h0);
    rd(ov[1], 3'h0);
    @(negedge clk);
    `CHK({overrun_flag, receive_available_flag}, 2'h0)
    i_serial_peer.send(ov[2], 2'h1);
    rd(ov[2], 3'h2);
    i_serial_peer.send(ov[1], 2'h2);
    rd(ov[1], 3'h1);
    {ten, ren} = 2'h0;
    repeat (2) @(negedge clk);
    `CHK({tx_oe, rx_claim, tx_out}, 3'h1)
    `CHK(txq.size() + rxq.size(), 0)
    close_out();
  end
endmodule
